// ### hw/pmd_defs.vh
// Constants for the per-channel level DAC load and reset default block
`ifndef PMD_DEFS_VH
`define PMD_DEFS_VH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define PMD_NDAC 5
`define PMD_NSLOT 6
`define PMD_SLOT_V 3'h0
`define PMD_SLOT_MAX 3'h5
`define PMD_RNG_MAX 3'h4
`define PMD_REG_W 22

// ------------------------------------------------------------
// DAC kinds inside one channel
// ------------------------------------------------------------
`define PMD_DAC_FORCE 0
`define PMD_DAC_LOLIM 1
`define PMD_DAC_HILIM 2
`define PMD_DAC_CMPLO 3
`define PMD_DAC_CMPHI 4

// ------------------------------------------------------------
// Access targets (write and read kind field)
// ------------------------------------------------------------
`define PMD_KIND_SYS 3'h0
`define PMD_KIND_PMU 3'h1
`define PMD_KIND_OFS 3'h2
`define PMD_KIND_CODE 3'h3
`define PMD_KIND_GAIN 3'h4
`define PMD_KIND_OFFS 3'h5
`define PMD_KIND_ALARM 3'h6
`define PMD_KIND_CMP 3'h7

// ------------------------------------------------------------
// Channel mode register fields
// ------------------------------------------------------------
`define PMD_PMU_FORCE_HI 20
`define PMD_PMU_FORCE_LO 19
`define PMD_PMU_RNG_HI 17
`define PMD_PMU_RNG_LO 15
`define PMD_PMU_CMP_VI 7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PMD_RST_GAIN 16'hFFFF
`define PMD_RST_COFS 16'h8000
`define PMD_RST_OFSDAC 16'hA492
`define PMD_RST_FORCE 16'h8000
`define PMD_RST_LOLIM 16'h0000
`define PMD_RST_HILIM 16'hFFFF
`define PMD_RST_CMPLO 16'h0000
`define PMD_RST_CMPHI 16'hFFFF
`define PMD_RST_RD 24'h00_0000
`define PMD_RST_ALARM 24'hFF_FFF0
`define PMD_RST_CMP 24'h40_0000
`define PMD_RST_SYS 22'h00_0020
`define PMD_RST_PMU 22'h01_E060

// ------------------------------------------------------------
// Calibration arithmetic
// ------------------------------------------------------------
`define PMD_MID 18'h0_8000
`define PMD_FULL 18'h0_FFFF
`define PMD_MID16 16'h8000
`define PMD_CODE_MIN 16'h0000
`define PMD_CODE_MAX 16'hFFFF

`endif

// ### hw/pmd_dac_load.v
// Level DAC calibration, storage, mode-driven load and power-on defaults
`include "pmd_defs.vh"

// Functional notes
// RULE_01 - Gain resets full-scale, offset coefficient midscale
// RULE_02 - Offset DAC and force DACs reset values
// RULE_03 - Low limits reset zero, high limits ones
// RULE_04 - Alarm status resets to its default
// RULE_05 - Comparator status resets to its default
// RULE_06 - System control zero except thermal enable
// RULE_07 - Mode register resets range, measure, alarm bits
// RULE_08 - Every channel and DAC starts known
// RULE_09 - Host writes system, coefficients, codes, then mode
// RULE_10 - Input code write computes and stores corrected
// RULE_11 - Mode write sets switches, loads stored codes
// RULE_12 - Inactive slot writes store but never output
// RULE_13 - Separate code slots per range, mode selects
// RULE_14 - Float modes put force amplifier high-impedance
// RULE_15 - Float modes auto-update force and limit DACs
// RULE_16 - Voltage forcing feeds current-range limit codes
// RULE_17 - Host preloads codes or floats before switching
// RULE_18 - Corrected result clamps to sixteen bits
module pmd_dac_load #(
  parameter NCH = 4,
  parameter CHW = 2
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // Register write port
  input wire wr_en_i,
  input wire [2:0] wr_kind_i,
  input wire [CHW-1:0] wr_ch_i,
  input wire [2:0] wr_dac_i,
  input wire [2:0] wr_slot_i,
  input wire [`PMD_REG_W-1:0] wr_data_i,
  // Register read port
  input wire rd_en_i,
  input wire [2:0] rd_kind_i,
  input wire [CHW-1:0] rd_ch_i,
  input wire [2:0] rd_dac_i,
  input wire [2:0] rd_slot_i,
  output reg [23:0] rd_data_o,
  output reg rd_valid_o,
  // DAC and switch outputs
  output wire [NCH*`PMD_NDAC*16-1:0] dac_code_o,
  output reg [15:0] offset_dac_o,
  output wire [NCH*`PMD_REG_W-1:0] chan_cfg_o,
  output reg [NCH-1:0] force_float_o,
  output reg [`PMD_REG_W-1:0] sys_ctrl_o
);

  localparam NENT = NCH * `PMD_NDAC * `PMD_NSLOT;
  localparam NCD = NCH * `PMD_NDAC;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function [15:0] pmd_def;
    input integer d;
    begin
      case (d)
        `PMD_DAC_FORCE: pmd_def = `PMD_RST_FORCE;
        `PMD_DAC_LOLIM: pmd_def = `PMD_RST_LOLIM;
        `PMD_DAC_HILIM: pmd_def = `PMD_RST_HILIM;
        `PMD_DAC_CMPLO: pmd_def = `PMD_RST_CMPLO;
        default: pmd_def = `PMD_RST_CMPHI;
      endcase
    end
  endfunction

  // Slot chosen by a mode word for one DAC kind
  function [2:0] pmd_slot;
    input [`PMD_REG_W-1:0] mode;
    input integer d;
    reg [2:0] rng;
    reg [2:0] cur;
    reg is_i;
    begin
      rng = mode[`PMD_PMU_RNG_HI:`PMD_PMU_RNG_LO];
      // Range codes past the last documented one share the top slot
      cur = (rng > `PMD_RNG_MAX) ? `PMD_SLOT_MAX : rng + 3'h1;
      is_i = mode[`PMD_PMU_FORCE_LO];
      case (d)
        `PMD_DAC_FORCE: pmd_slot = is_i ? cur : `PMD_SLOT_V;
        // Voltage forcing clamps current, so limits use current slots
        `PMD_DAC_LOLIM,
        `PMD_DAC_HILIM: pmd_slot = is_i ? `PMD_SLOT_V : cur;
        default: pmd_slot = mode[`PMD_PMU_CMP_VI] ? cur : `PMD_SLOT_V;
      endcase
    end
  endfunction

  // Corrected code: x * (m + 1) / 2^16 + c - midscale
  // Clamping keeps a large or small offset coefficient from wrapping a code to the far end of the range
  function [15:0] pmd_cal;
    input [15:0] x;
    input [15:0] m;
    input [15:0] c;
    reg [32:0] prod;
    reg [17:0] sum;
    begin
      prod = ({17'h0_0000, x} * {17'h0_0000, m}) + {17'h0_0000, x};
      sum = {2'b00, prod[31:16]} + {2'b00, c};
      if (sum < `PMD_MID) begin
        pmd_cal = `PMD_CODE_MIN;
      end else if (sum - `PMD_MID > `PMD_FULL) begin
        pmd_cal = `PMD_CODE_MAX;
      end else begin
        pmd_cal = sum[15:0] - `PMD_MID16;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  wire [31:0] wr_cd_w;
  wire [31:0] wr_idx_w;
  wire wr_addr_ok_w;
  wire code_wr_w;
  wire gain_wr_w;
  wire cofs_wr_w;
  wire pmu_wr_w;
  wire [NENT*16-1:0] code_flat;
  wire [NENT*16-1:0] corr_flat;
  wire [NCD*16-1:0] gain_flat;
  wire [NCD*16-1:0] cofs_flat;
  wire [15:0] cal_w;

  assign wr_cd_w = wr_ch_i * `PMD_NDAC + wr_dac_i;
  assign wr_idx_w = wr_cd_w * `PMD_NSLOT + wr_slot_i;
  assign wr_addr_ok_w = (wr_dac_i < `PMD_NDAC) && (wr_ch_i < NCH);
  // Out-of-range fields are dropped silently; no port reports them
  assign code_wr_w = wr_en_i && (wr_kind_i == `PMD_KIND_CODE) && wr_addr_ok_w &&
                     (wr_slot_i <= `PMD_SLOT_MAX);
  assign gain_wr_w = wr_en_i && (wr_kind_i == `PMD_KIND_GAIN) && wr_addr_ok_w;
  assign cofs_wr_w = wr_en_i && (wr_kind_i == `PMD_KIND_OFFS) && wr_addr_ok_w;
  assign pmu_wr_w = wr_en_i && (wr_kind_i == `PMD_KIND_PMU) && (wr_ch_i < NCH);

  // RULE_10 - Single-cycle correction
  // RULE_18 - Saturating result
  assign cal_w = pmd_cal(wr_data_i[15:0], gain_flat[wr_cd_w*16 +: 16],
                         cofs_flat[wr_cd_w*16 +: 16]);

  // ------------------------------------------------------------
  // Input and corrected code slots
  // ------------------------------------------------------------
  // Flops rather than a memory: every slot needs its own reset default
  genvar e;
  generate
    for (e = 0; e < NENT; e = e + 1) begin : g_ent
      reg [15:0] code_q;
      reg [15:0] corr_q;
      always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          // RULE_08 - Known slot defaults
          code_q <= pmd_def((e / `PMD_NSLOT) % `PMD_NDAC);
          corr_q <= pmd_def((e / `PMD_NSLOT) % `PMD_NDAC);
        end else if (code_wr_w && (wr_idx_w == e)) begin
          // RULE_13 - Per-range slot storage
          code_q <= wr_data_i[15:0];
          corr_q <= cal_w;
        end
      end
      assign code_flat[e*16 +: 16] = code_q;
      assign corr_flat[e*16 +: 16] = corr_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // Coefficients and DAC output registers
  // ------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NCD; k = k + 1) begin : g_dac
      localparam integer KD = k % `PMD_NDAC;
      localparam integer KC = k / `PMD_NDAC;
      reg [15:0] gain_q;
      reg [15:0] cofs_q;
      reg [15:0] dac_q;
      wire [2:0] new_slot_w;
      wire [2:0] act_slot_w;
      wire [31:0] new_idx_w;
      assign new_slot_w = pmd_slot(wr_data_i, KD);
      assign act_slot_w = pmd_slot(chan_cfg_o[KC*`PMD_REG_W +: `PMD_REG_W], KD);
      assign new_idx_w = k * `PMD_NSLOT + new_slot_w;
      always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          // RULE_01 - Coefficient defaults
          gain_q <= `PMD_RST_GAIN;
          cofs_q <= `PMD_RST_COFS;
          // RULE_02 - Force level defaults
          // RULE_03 - Limit and comparator defaults
          dac_q <= pmd_def(KD);
        end else begin
          if (gain_wr_w && (wr_cd_w == k)) begin
            gain_q <= wr_data_i[15:0];
          end
          if (cofs_wr_w && (wr_cd_w == k)) begin
            cofs_q <= wr_data_i[15:0];
          end
          // A mode write outranks a same-cycle code write to the old slot
          if (pmu_wr_w && (wr_ch_i == KC)) begin
            // RULE_11 - Mode write loads codes
            // RULE_15 - Float entry refreshes outputs
            // RULE_16 - Current-range limit codes
            dac_q <= corr_flat[new_idx_w*16 +: 16];
          end else if (code_wr_w && (wr_cd_w == k) && (wr_slot_i == act_slot_w)) begin
            // RULE_12 - Only active slot reaches output
            dac_q <= cal_w;
          end
        end
      end
      assign gain_flat[k*16 +: 16] = gain_q;
      assign cofs_flat[k*16 +: 16] = cofs_q;
      assign dac_code_o[k*16 +: 16] = dac_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // Channel mode registers
  // ------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      reg [`PMD_REG_W-1:0] pmu_q;
      always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          // RULE_07 - Mode register default
          pmu_q <= `PMD_RST_PMU;
        end else if (pmu_wr_w && (wr_ch_i == c)) begin
          // RULE_11 - Switch configuration update
          pmu_q <= wr_data_i;
        end
      end
      assign chan_cfg_o[c*`PMD_REG_W +: `PMD_REG_W] = pmu_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // Force amplifier release flags
  // ------------------------------------------------------------
  // One process owns the whole vector so no bit has two drivers
  integer fi;
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      force_float_o <= {NCH{1'b0}};
    end else begin
      for (fi = 0; fi < NCH; fi = fi + 1) begin
        if (pmu_wr_w && (wr_ch_i == fi)) begin
          // RULE_14 - Float modes release the amplifier
          force_float_o[fi] <= wr_data_i[`PMD_PMU_FORCE_HI];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Shared registers
  // ------------------------------------------------------------
  // Status words hold their defaults; no input port or logic ever updates them after reset
  reg [23:0] alarm_q;
  reg [23:0] cmp_q;
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // RULE_06 - System control default
      sys_ctrl_o <= `PMD_RST_SYS;
      // RULE_02 - Shared offset DAC default
      offset_dac_o <= `PMD_RST_OFSDAC;
      // RULE_04 - Alarm status default
      alarm_q <= `PMD_RST_ALARM;
      // RULE_05 - Comparator status default
      cmp_q <= `PMD_RST_CMP;
    end else begin
      if (wr_en_i && (wr_kind_i == `PMD_KIND_SYS)) begin
        sys_ctrl_o <= wr_data_i;
      end
      if (wr_en_i && (wr_kind_i == `PMD_KIND_OFS)) begin
        offset_dac_o <= wr_data_i[15:0];
      end
      alarm_q <= alarm_q;
      cmp_q <= cmp_q;
    end
  end

  // ------------------------------------------------------------
  // Readback
  // ------------------------------------------------------------
  wire [31:0] rd_cd_w;
  wire [31:0] rd_idx_w;
  wire rd_ok_w;
  reg [23:0] rd_d;
  assign rd_cd_w = rd_ch_i * `PMD_NDAC + rd_dac_i;
  assign rd_idx_w = rd_cd_w * `PMD_NSLOT + rd_slot_i;
  assign rd_ok_w = (rd_dac_i < `PMD_NDAC) && (rd_ch_i < NCH);

  // A read in the same cycle as a write returns the old value
  always @* begin
    rd_d = 24'h00_0000;
    case (rd_kind_i)
      `PMD_KIND_SYS: rd_d = {2'b00, sys_ctrl_o};
      `PMD_KIND_PMU: begin
        if (rd_ch_i < NCH) begin
          rd_d = {2'b00, chan_cfg_o[rd_ch_i*`PMD_REG_W +: `PMD_REG_W]};
        end
      end
      `PMD_KIND_OFS: rd_d = {8'h00, offset_dac_o};
      `PMD_KIND_CODE: begin
        if (rd_ok_w && (rd_slot_i <= `PMD_SLOT_MAX)) begin
          rd_d = {8'h00, code_flat[rd_idx_w*16 +: 16]};
        end
      end
      `PMD_KIND_GAIN: begin
        if (rd_ok_w) begin
          rd_d = {8'h00, gain_flat[rd_cd_w*16 +: 16]};
        end
      end
      `PMD_KIND_OFFS: begin
        if (rd_ok_w) begin
          rd_d = {8'h00, cofs_flat[rd_cd_w*16 +: 16]};
        end
      end
      `PMD_KIND_ALARM: rd_d = alarm_q;
      `PMD_KIND_CMP: rd_d = cmp_q;
      default: rd_d = 24'h00_0000;
    endcase
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= `PMD_RST_RD;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= rd_d;
      end
    end
  end

endmodule // pmd_dac_load

// ### sim/pmd_dac_load_props.sv
// Port assertions for the level DAC load block
module pmd_dac_load_chk #(
  parameter NCH = 4,
  parameter CHW = 2
) (
  // Clock, reset and requests
  input wire ref_clk_i,
  input wire nrst_i,
  input wire wr_en_i,
  input wire [2:0] wr_kind_i,
  input wire [CHW-1:0] wr_ch_i,
  input wire [21:0] wr_data_i,
  input wire rd_en_i,
  input wire [2:0] rd_kind_i,
  // Design outputs
  input wire [23:0] rd_data_o,
  input wire rd_valid_o,
  input wire [NCH*80-1:0] dac_code_o,
  input wire [15:0] offset_dac_o,
  input wire [NCH*22-1:0] chan_cfg_o,
  input wire [NCH-1:0] force_float_o,
  input wire [21:0] sys_ctrl_o
);
  // ------
  // Checks
  // ------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire mw = wr_en_i && wr_kind_i == 3'h1;
  a_sys_reset_value: assert property ($rose(nrst_i) |-> sys_ctrl_o == 22'h00_0020)
    else $error("system control reset value wrong");
  a_mode_reset_value: assert property ($rose(nrst_i) |-> chan_cfg_o == {NCH{22'h01_E060}})
    else $error("mode word reset value wrong");
  a_dac_reset_codes: assert property ($rose(nrst_i) |->
    dac_code_o == {NCH{80'hFFFF_0000_FFFF_0000_8000}}) else $error("DAC reset codes wrong");
  a_ofs_reset_value: assert property ($rose(nrst_i) |-> offset_dac_o == 16'hA492)
    else $error("offset DAC reset code wrong");
  a_alarm_read_value: assert property (rd_en_i && rd_kind_i == 3'h6 |=>
    rd_valid_o && rd_data_o == 24'hFF_FFF0) else $error("alarm status read wrong");
  a_cmp_read_value: assert property (rd_en_i && rd_kind_i == 3'h7 |=>
    rd_valid_o && rd_data_o == 24'h40_0000) else $error("comparator status read wrong");
  a_mode_word_store: assert property (mw |=>
    chan_cfg_o[$past(wr_ch_i)*22 +: 22] == $past(wr_data_i)) else $error("mode word not stored");
  a_float_follows_mode: assert property (mw |=>
    force_float_o[$past(wr_ch_i)] == $past(wr_data_i[20])) else $error("float flag wrong");
  a_dac_idle_hold: assert property (!(mw || (wr_en_i && wr_kind_i == 3'h3)) |=>
    $stable(dac_code_o) && $stable(force_float_o)) else $error("DAC moved without a load");
endmodule // pmd_dac_load_chk

bind pmd_dac_load pmd_dac_load_chk #(.NCH(NCH), .CHW(CHW)) u_pmd_dac_load_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i), .wr_kind_i(wr_kind_i),
  .wr_ch_i(wr_ch_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_kind_i(rd_kind_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .dac_code_o(dac_code_o),
  .offset_dac_o(offset_dac_o), .chan_cfg_o(chan_cfg_o), .force_float_o(force_float_o),
  .sys_ctrl_o(sys_ctrl_o));

// ### sim/pmd_host.sv
// Host controller model driving the write and read ports
module pmd_host (
  // Clock
  input wire ref_clk_i,
  // Write port
  output logic wr_en_o,
  output logic [2:0] wr_kind_o,
  output logic [1:0] wr_ch_o,
  output logic [2:0] wr_dac_o,
  output logic [2:0] wr_slot_o,
  output logic [21:0] wr_data_o,
  // Read port
  output logic rd_en_o,
  output logic [2:0] rd_kind_o,
  output logic [1:0] rd_ch_o,
  output logic [2:0] rd_dac_o,
  output logic [2:0] rd_slot_o,
  input wire [23:0] rd_data_i,
  input wire rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_en_o, wr_kind_o, wr_ch_o, wr_dac_o, wr_slot_o, wr_data_o} = '0;
    {rd_en_o, rd_kind_o, rd_ch_o, rd_dac_o, rd_slot_o} = '0;
  end
  // ----------
  // Host tasks
  // ----------
  // Data is inverted once released so a stale word is never mistaken for a write
  task automatic wr(input logic [2:0] k, input logic [1:0] c, input logic [2:0] d,
                    input logic [2:0] s, input logic [21:0] v);
    @(negedge ref_clk_i);
    {wr_en_o, wr_kind_o, wr_ch_o, wr_dac_o, wr_slot_o, wr_data_o} = {1'b1, k, c, d, s, v};
    @(negedge ref_clk_i);
    {wr_en_o, wr_data_o} = {1'b0, ~v};
  endtask
  task automatic rd(input logic [2:0] k, input logic [1:0] c, input logic [2:0] d,
                    input logic [2:0] s, output logic [23:0] q, output logic vld);
    @(negedge ref_clk_i);
    {rd_en_o, rd_kind_o, rd_ch_o, rd_dac_o, rd_slot_o} = {1'b1, k, c, d, s};
    @(negedge ref_clk_i);
    rd_en_o = 1'b0;
    q = rd_data_i;
    vld = rd_valid_i;
  endtask
endmodule // pmd_host

// ### sim/pmd_dac_load_test.sv
// Self-checking bench for the level DAC load block
module pmd_dac_load_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  wire wr_en, rd_en, rd_valid;
  wire [2:0] wr_kind, wr_dac, wr_slot, rd_kind, rd_dac, rd_slot;
  wire [1:0] wr_ch, rd_ch;
  wire [21:0] wr_data, sys_ctrl;
  wire [23:0] rd_data;
  wire [319:0] dac_code;
  wire [15:0] offset_dac;
  wire [87:0] chan_cfg;
  wire [3:0] force_float;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  pmd_dac_load u_pmd_dac_load (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wr_en_i(wr_en),
    .wr_kind_i(wr_kind), .wr_ch_i(wr_ch), .wr_dac_i(wr_dac), .wr_slot_i(wr_slot),
    .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_kind_i(rd_kind), .rd_ch_i(rd_ch),
    .rd_dac_i(rd_dac), .rd_slot_i(rd_slot), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .dac_code_o(dac_code), .offset_dac_o(offset_dac), .chan_cfg_o(chan_cfg),
    .force_float_o(force_float), .sys_ctrl_o(sys_ctrl));
  pmd_host u_pmd_host (.ref_clk_i(ref_clk_i), .wr_en_o(wr_en), .wr_kind_o(wr_kind),
    .wr_ch_o(wr_ch), .wr_dac_o(wr_dac), .wr_slot_o(wr_slot), .wr_data_o(wr_data),
    .rd_en_o(rd_en), .rd_kind_o(rd_kind), .rd_ch_o(rd_ch), .rd_dac_o(rd_dac),
    .rd_slot_o(rd_slot), .rd_data_i(rd_data), .rd_valid_i(rd_valid));
  // -------
  // Helpers
  // -------
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cd(input logic [1:0] c, input logic [2:0] d, input logic [15:0] e);
    chk("dac code", {8'h00, e}, {8'h00, dac_code[(c*5+d)*16 +: 16]});
  endtask
  task automatic rc(input logic [2:0] k, input logic [1:0] c, input logic [2:0] d,
                    input logic [2:0] s, input logic [23:0] e, input logic [23:0] m);
    logic [23:0] q;
    logic vld;
    u_pmd_host.rd(k, c, d, s, q, vld);
    chk("read valid", 24'h00_0001, {23'h0, vld});
    chk("read data", e, q & m);
  endtask
  // Saturate rather than wrap, as the block must
  function automatic logic [15:0] corr(input logic [15:0] x, m, c);
    logic [33:0] p;
    p = ((x * (m + 17'h1)) >> 16) + c;
    corr = (p < 34'h8000) ? 16'h0000 : (p > 34'h1_7FFF) ? 16'hFFFF : 16'(p - 34'h8000);
  endfunction
  // ---------
  // Scenarios
  // ---------
  task automatic t_defaults;
    for (int c = 0; c < 4; c++) begin
      cd(c[1:0], 3'h0, 16'h8000);
      for (int d = 1; d < 5; d++) cd(c[1:0], d[2:0], d[0] ? 16'h0000 : 16'hFFFF);
      rc(3'h4, c[1:0], 3'h2, 3'h0, 24'h00_FFFF, 24'h00_FFFF);
      rc(3'h5, c[1:0], 3'h4, 3'h0, 24'h00_8000, 24'h00_FFFF);
      rc(3'h1, c[1:0], 3'h0, 3'h0, 24'h01_E060, 24'h3F_FFFF);
      rc(3'h3, c[1:0], 3'h2, 3'h5, 24'h00_FFFF, 24'h00_FFFF);
    end
    rc(3'h0, 2'h0, 3'h0, 3'h0, 24'h00_0020, 24'h3F_FFFF);
    rc(3'h2, 2'h0, 3'h0, 3'h0, 24'h00_A492, 24'h00_FFFF);
    rc(3'h6, 2'h0, 3'h0, 3'h0, 24'hFF_FFF0, 24'hFF_FFFF);
    rc(3'h7, 2'h0, 3'h0, 3'h0, 24'h40_0000, 24'hFF_FFFF);
    chk("float", 24'h00_0000, {20'h0_0000, force_float});
  endtask
  task automatic t_calib;
    logic [15:0] v [3][3] = '{'{16'h1234, 16'h8000, 16'h9000},
      '{16'hFFFF, 16'hFFFF, 16'hFFFF}, '{16'h0000, 16'h0000, 16'h0000}};
    u_pmd_host.wr(3'h0, 2'h0, 3'h0, 3'h0, 22'h00_0060);
    chk("sys ctrl", 24'h00_0060, {2'h0, sys_ctrl});
    for (int i = 0; i < 3; i++) begin
      u_pmd_host.wr(3'h4, 2'h1, 3'h0, 3'h0, {6'h00, v[i][1]});
      u_pmd_host.wr(3'h5, 2'h1, 3'h0, 3'h0, {6'h00, v[i][2]});
      u_pmd_host.wr(3'h3, 2'h1, 3'h0, 3'h0, {6'h00, v[i][0]});
      cd(2'h1, 3'h0, corr(v[i][0], v[i][1], v[i][2]));
    end
  endtask
  task automatic t_slots;
    u_pmd_host.wr(3'h3, 2'h2, 3'h0, 3'h2, 22'h00_1111);
    cd(2'h2, 3'h0, 16'h8000);
    u_pmd_host.wr(3'h3, 2'h2, 3'h1, 3'h2, 22'h00_2222);
    u_pmd_host.wr(3'h3, 2'h2, 3'h4, 3'h2, 22'h00_5555);
    cd(2'h2, 3'h1, 16'h0000);
    rc(3'h3, 2'h2, 3'h0, 3'h2, 24'h00_1111, 24'h00_FFFF);
    u_pmd_host.wr(3'h1, 2'h2, 3'h0, 3'h0, 22'h08_8000);
    chk("mode word", 24'h08_8000, {2'h0, chan_cfg[44 +: 22]});
    cd(2'h2, 3'h0, 16'h1111);
    cd(2'h2, 3'h1, 16'h0000);
    u_pmd_host.wr(3'h1, 2'h2, 3'h0, 3'h0, 22'h00_8080);
    cd(2'h2, 3'h0, 16'h8000);
    cd(2'h2, 3'h1, 16'h2222);
    cd(2'h2, 3'h4, 16'h5555);
  endtask
  task automatic t_float;
    u_pmd_host.wr(3'h3, 2'h3, 3'h0, 3'h0, 22'h00_3333);
    cd(2'h3, 3'h0, 16'h3333);
    u_pmd_host.wr(3'h3, 2'h3, 3'h2, 3'h1, 22'h00_4444);
    u_pmd_host.wr(3'h1, 2'h3, 3'h0, 3'h0, 22'h10_0000);
    chk("float", 24'h00_0008, {20'h0_0000, force_float});
    cd(2'h3, 3'h0, 16'h3333);
    cd(2'h3, 3'h2, 16'h4444);
    u_pmd_host.wr(3'h1, 2'h3, 3'h0, 3'h0, 22'h18_0000);
    chk("float", 24'h00_0008, {20'h0_0000, force_float});
    cd(2'h3, 3'h0, 16'h8000);
    cd(2'h3, 3'h2, 16'hFFFF);
  endtask
  task automatic t_misc;
    u_pmd_host.wr(3'h2, 2'h0, 3'h0, 3'h0, 22'h00_5A5A);
    chk("offset dac", 24'h00_5A5A, {8'h00, offset_dac});
    u_pmd_host.wr(3'h6, 2'h0, 3'h0, 3'h0, 22'h00_0000);
    rc(3'h6, 2'h0, 3'h0, 3'h0, 24'hFF_FFF0, 24'hFF_FFFF);
    u_pmd_host.wr(3'h3, 2'h0, 3'h0, 3'h7, 22'h00_0001);
    cd(2'h0, 3'h0, 16'h8000);
    rc(3'h3, 2'h0, 3'h0, 3'h7, 24'h00_0000, 24'hFF_FFFF);
    rc(3'h3, 2'h0, 3'h1, 3'h1, 24'h00_0000, 24'h00_FFFF);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // A healthy run needs about 140 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_defaults;
    t_calib;
    t_slots;
    t_float;
    t_misc;
    @(negedge ref_clk_i);
    nrst_i = 1'b0;
    @(negedge ref_clk_i);
    nrst_i = 1'b1;
    t_defaults;
    final_report;
  end
endmodule // pmd_dac_load_test
